// ===== shared/freq_monitor_pkg.sv
package freq_monitor_pkg;

    // =========================================================
    // register bus
    // =========================================================
    localparam int ADDR_W = 10;
    localparam int DATA_W = 8;
    localparam int IDX_W = 8;

    // register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_MON_CFG = 8'h48;
    localparam logic [IDX_W-1:0] IDX_SRC_SEL = 8'h4B;
    localparam logic [IDX_W-1:0] IDX_MEAS = 8'h4C;
    localparam logic [IDX_W-1:0] IDX_SOFT_LIM = 8'h4D;
    localparam logic [IDX_W-1:0] IDX_IRQ_STS = 8'h4E;
    localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 8'h4F;

    localparam logic [1:0] ADDR_PAD = 2'h0;

    // =========================================================
    // field layouts
    // =========================================================
    localparam int MON_CLK_SEL_BIT = 7;
    localparam int T4T0_SEL_BIT = 4;
    localparam int CHAN_SEL_LSB = 0;
    localparam int CHAN_SEL_W = 4;
    localparam int LIMIT_FORCE_BIT = 7;
    localparam int SOFT_BOUND_LSB = 0;
    localparam int SOFT_BOUND_W = 7;

    localparam int IRQ_W = 3;
    localparam int IRQ_MEAS_BIT = 0;
    localparam int IRQ_FORCE0_BIT = 1;
    localparam int IRQ_FORCE1_BIT = 2;

    // =========================================================
    // reset values
    // =========================================================
    localparam logic [DATA_W-1:0] MON_CFG_RST = 8'h00;
    localparam logic [DATA_W-1:0] SRC_SEL_RST = 8'h00;
    localparam logic [DATA_W-1:0] SOFT_LIM_RST = 8'h8E;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;

    // =========================================================
    // measurement
    // =========================================================
    localparam int NUM_CHAN = 14;
    localparam int NUM_DPLL = 2;
    localparam int CNT_W = 16;
    // gate length in reference edges; both clocks are nominally equal
    localparam logic [CNT_W-1:0] GATE_REF_EDGES = 16'h0400;
    localparam logic [CHAN_SEL_W-1:0] CHAN_FIRST = 4'h1;
    localparam logic [CHAN_SEL_W-1:0] CHAN_LAST = 4'hE;
    localparam logic signed [CNT_W:0] MEAS_MAX = 17'sh0007F;
    localparam logic signed [CNT_W:0] MEAS_MIN = -17'sh00080;

    function automatic logic [ADDR_W-1:0] byteAddr(input logic [IDX_W-1:0] idx);
        byteAddr = {idx, ADDR_PAD};
    endfunction

endpackage

// ===== core/freq_offset_meter.sv
module freq_offset_meter (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [freq_monitor_pkg::NUM_CHAN-1:0] chanIn,
    input wire logic xtalIn,
    input wire logic dpllOutIn,
    input wire logic [freq_monitor_pkg::CHAN_SEL_W-1:0] chanSel,
    input wire logic refSel,
    output logic [freq_monitor_pkg::DATA_W-1:0] result,
    output logic resultValid
);
    localparam int NS = freq_monitor_pkg::NUM_CHAN + 2;

    // =========================================================
    // input synchronisers and edge detect
    // =========================================================
    logic [NS-1:0] meta_r, sync_r, prev_r;
    logic [NS-1:0] edges;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_r <= '0;
            sync_r <= '0;
            prev_r <= '0;
        end else begin
            meta_r <= {dpllOutIn, xtalIn, chanIn};
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    assign edges = sync_r & ~prev_r;

    // =========================================================
    // gate counters
    // =========================================================
    logic [freq_monitor_pkg::CNT_W-1:0] refCnt_r, refCnt_nxt, inCnt_r, inCnt_nxt;
    logic [freq_monitor_pkg::DATA_W-1:0] result_r, result_nxt;
    logic valid_r, valid_nxt;
    logic [freq_monitor_pkg::CHAN_SEL_W-1:0] selHeld_r;
    logic refHeld_r;
    logic refEdge, inEdge, chanOk, restart;

    // signed saturation of a count difference to the result byte
    function automatic logic [freq_monitor_pkg::DATA_W-1:0] sat8(input logic signed [freq_monitor_pkg::CNT_W:0] d);
        if (d > freq_monitor_pkg::MEAS_MAX)
            sat8 = freq_monitor_pkg::MEAS_MAX[freq_monitor_pkg::DATA_W-1:0];
        else if (d < freq_monitor_pkg::MEAS_MIN)
            sat8 = freq_monitor_pkg::MEAS_MIN[freq_monitor_pkg::DATA_W-1:0];
        else
            sat8 = d[freq_monitor_pkg::DATA_W-1:0];
    endfunction

    always_comb begin
        chanOk = (chanSel >= freq_monitor_pkg::CHAN_FIRST) && (chanSel <= freq_monitor_pkg::CHAN_LAST);
        // reference is crystal or main dpll output
        refEdge = refSel ? edges[NS-1] : edges[NS-2];
        inEdge = chanOk ? edges[chanSel - freq_monitor_pkg::CHAN_FIRST] : 1'b0;
        // a selection change would mix two inputs in one window
        restart = (chanSel != selHeld_r) || (refSel != refHeld_r);
        refCnt_nxt = refCnt_r;
        inCnt_nxt = inCnt_r;
        result_nxt = result_r;
        valid_nxt = 1'b0;
        if (restart) begin
            refCnt_nxt = '0;
            inCnt_nxt = '0;
        end else if (refEdge && (refCnt_r == freq_monitor_pkg::GATE_REF_EDGES - 16'h0001)) begin
            // offset against the monitor clock, two's complement
            result_nxt = chanOk ? sat8($signed({1'b0, inCnt_nxt + {15'h0000, inEdge}})
                                       - $signed({1'b0, freq_monitor_pkg::GATE_REF_EDGES}))
                                : freq_monitor_pkg::ZERO_BYTE;
            valid_nxt = 1'b1;
            refCnt_nxt = '0;
            inCnt_nxt = '0;
        end else begin
            refCnt_nxt = refCnt_r + {15'h0000, refEdge};
            inCnt_nxt = inCnt_r + {15'h0000, inEdge};
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            refCnt_r <= '0;
            inCnt_r <= '0;
            result_r <= freq_monitor_pkg::ZERO_BYTE;
            valid_r <= 1'b0;
            selHeld_r <= '0;
            refHeld_r <= 1'b0;
        end else begin
            refCnt_r <= refCnt_nxt;
            inCnt_r <= inCnt_nxt;
            result_r <= result_nxt;
            valid_r <= valid_nxt;
            selHeld_r <= chanSel;
            refHeld_r <= refSel;
        end
    end

    assign result = result_r;
    assign resultValid = valid_r;

endmodule // freq_offset_meter

// ===== core/dpll_freq_monitor_regs.sv
// Function
// - result byte shows frequency measurement of the input chosen by source select
// - result is offset relative to the monitor clock, not absolute frequency
// - monitor reference is crystal or main dpll output, per clock select bit
// - force bit set: dpll at hard limit enters phase lost; else normal detection
//
// Design decision made here: the address-and-strobe port.
module dpll_freq_monitor_regs (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [freq_monitor_pkg::ADDR_W-1:0] addr,
    input wire logic [freq_monitor_pkg::DATA_W-1:0] wrData,
    input wire logic wrEn,
    input wire logic rdEn,
    output logic [freq_monitor_pkg::DATA_W-1:0] rdData,
    input wire logic [freq_monitor_pkg::NUM_CHAN-1:0] chanIn,
    input wire logic xtalIn,
    input wire logic dpllOutIn,
    input wire logic [freq_monitor_pkg::NUM_DPLL-1:0] hardLimitHit,
    input wire logic [freq_monitor_pkg::NUM_DPLL-1:0] phaseLostDet,
    input wire logic [freq_monitor_pkg::NUM_DPLL-1:0] lockedDet,
    output logic [freq_monitor_pkg::NUM_DPLL-1:0] phaseLost,
    output logic [freq_monitor_pkg::NUM_DPLL-1:0] locked,
    output logic [freq_monitor_pkg::SOFT_BOUND_W-1:0] softTrackingBound,
    output logic t4T0Select,
    output logic irq
);

    // =========================================================
    // address decode
    // =========================================================
    logic hitMon, hitSrc, hitMeas, hitSoft, hitSts, hitMask;

    always_comb begin
        hitMon = (addr == freq_monitor_pkg::byteAddr(freq_monitor_pkg::IDX_MON_CFG));
        hitSrc = (addr == freq_monitor_pkg::byteAddr(freq_monitor_pkg::IDX_SRC_SEL));
        hitMeas = (addr == freq_monitor_pkg::byteAddr(freq_monitor_pkg::IDX_MEAS));
        hitSoft = (addr == freq_monitor_pkg::byteAddr(freq_monitor_pkg::IDX_SOFT_LIM));
        hitSts = (addr == freq_monitor_pkg::byteAddr(freq_monitor_pkg::IDX_IRQ_STS));
        hitMask = (addr == freq_monitor_pkg::byteAddr(freq_monitor_pkg::IDX_IRQ_MASK));
    end

    // =========================================================
    // configuration registers
    // =========================================================
    logic monClkSel_r, monClkSel_nxt;
    logic [freq_monitor_pkg::DATA_W-1:0] srcSel_r, srcSel_nxt;
    logic [freq_monitor_pkg::DATA_W-1:0] softLim_r, softLim_nxt;
    logic [freq_monitor_pkg::IRQ_W-1:0] irqMask_r, irqMask_nxt;

    always_comb begin
        monClkSel_nxt = monClkSel_r;
        srcSel_nxt = srcSel_r;
        softLim_nxt = softLim_r;
        irqMask_nxt = irqMask_r;
        if (wrEn) begin
            if (hitMon)
                monClkSel_nxt = wrData[freq_monitor_pkg::MON_CLK_SEL_BIT];
            if (hitSrc) begin
                // unused upper bits of source select are not stored
                srcSel_nxt = freq_monitor_pkg::ZERO_BYTE;
                srcSel_nxt[freq_monitor_pkg::T4T0_SEL_BIT] = wrData[freq_monitor_pkg::T4T0_SEL_BIT];
                srcSel_nxt[freq_monitor_pkg::CHAN_SEL_LSB +: freq_monitor_pkg::CHAN_SEL_W] =
                    wrData[freq_monitor_pkg::CHAN_SEL_LSB +: freq_monitor_pkg::CHAN_SEL_W];
            end
            if (hitSoft)
                softLim_nxt = wrData;
            if (hitMask)
                irqMask_nxt = wrData[freq_monitor_pkg::IRQ_W-1:0];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            monClkSel_r <= freq_monitor_pkg::MON_CFG_RST[freq_monitor_pkg::MON_CLK_SEL_BIT];
            srcSel_r <= freq_monitor_pkg::SRC_SEL_RST;
            softLim_r <= freq_monitor_pkg::SOFT_LIM_RST;
            irqMask_r <= freq_monitor_pkg::IRQ_MASK_RST;
        end else begin
            monClkSel_r <= monClkSel_nxt;
            srcSel_r <= srcSel_nxt;
            softLim_r <= softLim_nxt;
            irqMask_r <= irqMask_nxt;
        end
    end

    // =========================================================
    // frequency measurement
    // =========================================================
    logic [freq_monitor_pkg::DATA_W-1:0] measResult;
    logic measValid;

    freq_offset_meter u_meter (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .chanIn(chanIn),
        .xtalIn(xtalIn),
        .dpllOutIn(dpllOutIn),
        .chanSel(srcSel_r[freq_monitor_pkg::CHAN_SEL_LSB +: freq_monitor_pkg::CHAN_SEL_W]),
        .refSel(monClkSel_r),
        .result(measResult),
        .resultValid(measValid)
    );

    // =========================================================
    // phase lost forcing
    // =========================================================
    logic [freq_monitor_pkg::NUM_DPLL-1:0] phaseLost_r, phaseLost_nxt;
    logic [freq_monitor_pkg::NUM_DPLL-1:0] locked_r, locked_nxt;
    logic [freq_monitor_pkg::NUM_DPLL-1:0] forced, forcedPrev_r, forceRise;
    logic limitForcesPhaseLost;

    always_comb begin
        limitForcesPhaseLost = softLim_r[freq_monitor_pkg::LIMIT_FORCE_BIT];
        // with the bit clear the detectors pass straight through
        forced = limitForcesPhaseLost ? hardLimitHit : '0;
        phaseLost_nxt = phaseLostDet | forced;
        locked_nxt = lockedDet & ~forced;
        forceRise = forced & ~forcedPrev_r;
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            phaseLost_r <= '0;
            locked_r <= '0;
            forcedPrev_r <= '0;
        end else begin
            phaseLost_r <= phaseLost_nxt;
            locked_r <= locked_nxt;
            forcedPrev_r <= forced;
        end
    end

    // =========================================================
    // interrupts
    // =========================================================
    logic [freq_monitor_pkg::IRQ_W-1:0] irqSts_r, irqSts_nxt, irqSet, irqClr;
    logic irq_r, irq_nxt;

    always_comb begin
        irqSet = '0;
        irqSet[freq_monitor_pkg::IRQ_MEAS_BIT] = measValid;
        irqSet[freq_monitor_pkg::IRQ_FORCE0_BIT] = forceRise[0];
        irqSet[freq_monitor_pkg::IRQ_FORCE1_BIT] = forceRise[1];
        irqClr = (wrEn && hitSts) ? wrData[freq_monitor_pkg::IRQ_W-1:0] : '0;
        // set beats a same-cycle clear so no event is lost
        irqSts_nxt = (irqSts_r & ~irqClr) | irqSet;
        irq_nxt = |(irqSts_nxt & irqMask_nxt);
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            irqSts_r <= '0;
            irq_r <= 1'b0;
        end else begin
            irqSts_r <= irqSts_nxt;
            irq_r <= irq_nxt;
        end
    end

    // =========================================================
    // read back
    // =========================================================
    logic [freq_monitor_pkg::DATA_W-1:0] rdData_r, rdData_nxt;

    always_comb begin
        rdData_nxt = freq_monitor_pkg::ZERO_BYTE;
        if (rdEn) begin
            if (hitMon)
                rdData_nxt[freq_monitor_pkg::MON_CLK_SEL_BIT] = monClkSel_r;
            else if (hitSrc)
                rdData_nxt = srcSel_r;
            else if (hitMeas)
                rdData_nxt = measResult;
            else if (hitSoft)
                rdData_nxt = softLim_r;
            else if (hitSts)
                rdData_nxt[freq_monitor_pkg::IRQ_W-1:0] = irqSts_r;
            else if (hitMask)
                rdData_nxt[freq_monitor_pkg::IRQ_W-1:0] = irqMask_r;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b)
            rdData_r <= freq_monitor_pkg::ZERO_BYTE;
        else
            rdData_r <= rdData_nxt;
    end

    // =========================================================
    // outputs
    // =========================================================
    logic [freq_monitor_pkg::SOFT_BOUND_W-1:0] softBound_r;
    logic t4T0_r;

    // registered copies keep every output on a flop
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            softBound_r <= freq_monitor_pkg::SOFT_LIM_RST[freq_monitor_pkg::SOFT_BOUND_LSB +: freq_monitor_pkg::SOFT_BOUND_W];
            t4T0_r <= freq_monitor_pkg::SRC_SEL_RST[freq_monitor_pkg::T4T0_SEL_BIT];
        end else begin
            softBound_r <= softLim_r[freq_monitor_pkg::SOFT_BOUND_LSB +: freq_monitor_pkg::SOFT_BOUND_W];
            t4T0_r <= srcSel_r[freq_monitor_pkg::T4T0_SEL_BIT];
        end
    end

    assign rdData = rdData_r;
    assign phaseLost = phaseLost_r;
    assign locked = locked_r;
    assign softTrackingBound = softBound_r;
    assign t4T0Select = t4T0_r;
    assign irq = irq_r;

endmodule // dpll_freq_monitor_regs

// ===== test/dpll_freq_monitor_regs_checker.sv
module dpll_freq_monitor_regs_checker (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [freq_monitor_pkg::ADDR_W-1:0] addr,
    input wire logic [freq_monitor_pkg::DATA_W-1:0] wrData,
    input wire logic wrEn,
    input wire logic rdEn,
    input wire logic [freq_monitor_pkg::DATA_W-1:0] rdData,
    input wire logic [freq_monitor_pkg::NUM_CHAN-1:0] chanIn,
    input wire logic xtalIn,
    input wire logic dpllOutIn,
    input wire logic [freq_monitor_pkg::NUM_DPLL-1:0] hardLimitHit,
    input wire logic [freq_monitor_pkg::NUM_DPLL-1:0] phaseLostDet,
    input wire logic [freq_monitor_pkg::NUM_DPLL-1:0] lockedDet,
    input wire logic [freq_monitor_pkg::NUM_DPLL-1:0] phaseLost,
    input wire logic [freq_monitor_pkg::NUM_DPLL-1:0] locked,
    input wire logic [freq_monitor_pkg::SOFT_BOUND_W-1:0] softTrackingBound,
    input wire logic t4T0Select,
    input wire logic irq
);
    // =========================================================
    // properties
    // =========================================================
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    a_rd_idle_zero: assert property (!rdEn |=> rdData == 8'h00) else $error("read data not zero when idle");
    a_cfg_unused_zero: assert property (rdEn && addr == {freq_monitor_pkg::IDX_MON_CFG, 2'h0}
        |=> rdData[6:0] == 7'h00) else $error("monitor config unused bits not zero");
    a_force_excl_state: assert property (hardLimitHit[0] && lockedDet[0] && !phaseLostDet[0]
        |=> phaseLost[0] != locked[0]) else $error("limit hit gives inconsistent lost and locked");
    a_lost_normal_follow: assert property (!hardLimitHit[1]
        |=> phaseLost[1] == $past(phaseLostDet[1])) else $error("phase lost not following detection");
    a_locked_normal_follow: assert property (!hardLimitHit[0]
        |=> locked[0] == $past(lockedDet[0])) else $error("locked not following detection");
    a_bound_write_follow: assert property (wrEn && addr == {freq_monitor_pkg::IDX_SOFT_LIM, 2'h0}
        |-> ##2 softTrackingBound == $past(wrData[6:0], 2)) else $error("soft bound not taken from write");
    a_bound_hold_quiet: assert property (!$stable(softTrackingBound) |-> $past(wrEn, 2))
        else $error("soft bound changed without a write");
    a_select_write_follow: assert property (wrEn && addr == {freq_monitor_pkg::IDX_SRC_SEL, 2'h0}
        |-> ##2 t4T0Select == $past(wrData[4], 2)) else $error("path select not taken from write");
    a_mask_zero_quiet: assert property (wrEn && addr == {freq_monitor_pkg::IDX_IRQ_MASK, 2'h0} && wrData[2:0] == 3'h0
        |-> ##2 !irq) else $error("interrupt high with all sources masked");
endmodule // dpll_freq_monitor_regs_checker

bind dpll_freq_monitor_regs dpll_freq_monitor_regs_checker i_dpll_freq_monitor_regs_checker (.ref_clk, .rst_b,
    .addr, .wrData, .wrEn, .rdEn, .rdData, .chanIn, .xtalIn, .dpllOutIn, .hardLimitHit, .phaseLostDet,
    .lockedDet, .phaseLost, .locked, .softTrackingBound, .t4T0Select, .irq);

// ===== test/dpll_freq_monitor_regs_tb_top.sv
module dpll_freq_monitor_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // =========================================================
    // signals
    // =========================================================
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [9:0] addr = 10'h000;
    logic [7:0] wrData = 8'h00;
    logic wrEn = 1'b0;
    logic rdEn = 1'b0;
    logic [7:0] rdData;
    logic [13:0] chanIn = 14'h0000;
    logic xtalIn = 1'b0;
    logic dpllOutIn = 1'b0;
    logic [1:0] hardLimitHit = 2'h0;
    logic [1:0] phaseLostDet = 2'h0;
    logic [1:0] lockedDet = 2'h3;
    logic [1:0] phaseLost;
    logic [1:0] locked;
    logic [6:0] softTrackingBound;
    logic t4T0Select;
    logic irq;
    int cyc = 0;
    int failCount = 0;
    int cmpCount = 0;
    logic [7:0] v;

    dpll_freq_monitor_regs i_dpll_freq_monitor_regs (.ref_clk(ref_clk), .rst_b(rst_b), .addr(addr),
        .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData), .chanIn(chanIn), .xtalIn(xtalIn),
        .dpllOutIn(dpllOutIn), .hardLimitHit(hardLimitHit), .phaseLostDet(phaseLostDet), .lockedDet(lockedDet),
        .phaseLost(phaseLost), .locked(locked), .softTrackingBound(softTrackingBound), .t4T0Select(t4T0Select),
        .irq(irq));

    initial begin
        forever #2 ref_clk = ~ref_clk;
    end

    // divided clocks: crystal /8, dpll /6, input 3 fast /7, all others slow /10
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        xtalIn <= (cyc % 8) < 4;
        dpllOutIn <= (cyc % 6) < 3;
        for (int k = 0; k < 14; k++) begin
            chanIn[k] <= (k == 2) ? ((cyc % 7) < 3) : ((cyc % 10) < 5);
        end
    end

    // =========================================================
    // helpers
    // =========================================================
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmpCount++;
        if (got !== exp) begin
            failCount++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        @(posedge ref_clk);
        addr <= {idx, 2'h0};
        wrData <= d;
        wrEn <= 1'b1;
        @(posedge ref_clk);
        wrEn <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] idx, output logic [7:0] d);
        @(posedge ref_clk);
        addr <= {idx, 2'h0};
        rdEn <= 1'b1;
        @(posedge ref_clk);
        rdEn <= 1'b0;
        #1;
        d = rdData;
    endtask

    task automatic settle();
        repeat (2) @(posedge ref_clk);
        #1;
    endtask

    // =========================================================
    // scenarios
    // =========================================================
    task automatic testResetMap();
        rd(freq_monitor_pkg::IDX_SOFT_LIM, v); chk(v, 8'h8E);
        chk({1'b0, softTrackingBound}, 8'h0E);
        rd(freq_monitor_pkg::IDX_IRQ_MASK, v); chk(v, 8'h00);
        rd(8'h49, v); chk(v, 8'h00);
        wr(freq_monitor_pkg::IDX_SRC_SEL, 8'hF0);
        settle();
        chk({7'h0, t4T0Select}, 8'h01);
        rd(freq_monitor_pkg::IDX_SRC_SEL, v); chk(v, 8'h10);
        $display("test reset_map done");
    endtask

    task automatic testForce();
        wr(freq_monitor_pkg::IDX_SOFT_LIM, 8'h8E);
        wr(freq_monitor_pkg::IDX_IRQ_STS, 8'h07);
        hardLimitHit <= 2'h1;
        settle();
        chk({6'h0, phaseLost}, 8'h01);
        chk({6'h0, locked}, 8'h02);
        chk({7'h0, irq}, 8'h00);
        rd(freq_monitor_pkg::IDX_IRQ_STS, v); chk(v & 8'h06, 8'h02);
        wr(freq_monitor_pkg::IDX_IRQ_MASK, 8'h02);
        settle();
        chk({7'h0, irq}, 8'h01);
        wr(freq_monitor_pkg::IDX_IRQ_STS, 8'h02);
        settle();
        chk({7'h0, irq}, 8'h00);
        wr(freq_monitor_pkg::IDX_SOFT_LIM, 8'h0E);
        settle();
        chk({6'h0, phaseLost}, 8'h00);
        chk({6'h0, locked}, 8'h03);
        @(posedge ref_clk);
        hardLimitHit <= 2'h0;
        phaseLostDet <= 2'h2;
        lockedDet <= 2'h1;
        settle();
        chk({6'h0, phaseLost}, 8'h02);
        chk({6'h0, locked}, 8'h01);
        $display("test force done");
    endtask

    // offsets saturate so the expected byte does not hinge on edge phase
    task automatic meas(input logic [7:0] cfg, input logic [7:0] sel, output logic [7:0] d);
        int n;
        wr(freq_monitor_pkg::IDX_MON_CFG, cfg);
        wr(freq_monitor_pkg::IDX_SRC_SEL, sel);
        wr(freq_monitor_pkg::IDX_IRQ_STS, 8'h07);
        settle();
        n = 0;
        while (irq !== 1'b1 && n < 20000) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        if (n >= 20000) begin
            failCount++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, irq, 1'b1);
        end
        rd(freq_monitor_pkg::IDX_MEAS, d);
    endtask

    task automatic testMeasure();
        wr(freq_monitor_pkg::IDX_IRQ_MASK, 8'h01);
        meas(8'h00, 8'h03, v); chk(v, 8'h7F);
        wr(freq_monitor_pkg::IDX_MEAS, 8'h00);
        rd(freq_monitor_pkg::IDX_MEAS, v); chk(v, 8'h7F);
        meas(8'h00, 8'h04, v); chk(v, 8'h80);
        meas(8'h80, 8'h03, v); chk(v, 8'h80);
        rd(freq_monitor_pkg::IDX_MON_CFG, v); chk(v, 8'h80);
        meas(8'h00, 8'h00, v); chk(v, 8'h00);
        wr(freq_monitor_pkg::IDX_IRQ_MASK, 8'h00);
        settle();
        chk({7'h0, irq}, 8'h00);
        $display("test measure done");
    endtask

    // =========================================================
    // run control
    // =========================================================
    task automatic results();
        $display("comparisons %0d mismatches %0d", cmpCount, failCount);
        if (failCount == 0 && cmpCount > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge ref_clk);
        failCount++;
        results();
    end

    initial begin
        repeat (5) @(posedge ref_clk);
        rst_b <= 1'b1;
        testResetMap();
        testForce();
        testMeasure();
        results();
    end
endmodule // dpll_freq_monitor_regs_tb_top
